// ---- logic/pdr_defs.svh ----
// Constants for the discovery response block
`ifndef PDR_DEFS_SVH
`define PDR_DEFS_SVH
`define PDR_REG_CTRL       8'h00
`define PDR_REG_ADDR_LO    8'h04
`define PDR_REG_ADDR_HI    8'h08
`define PDR_REG_RDELAY     8'h0c
`define PDR_REG_BACKOFF    8'h10
`define PDR_REG_LENS       8'h14
`define PDR_REG_STATUS     8'h18
`define PDR_REG_RANGING    8'h1c
`define PDR_REG_POWER      8'h20
`define PDR_CTRL_READY_BIT 0
`define PDR_CTRL_REJOIN_BIT 1
`define PDR_PRBS_SEED      7'h55
`define PDR_CRC_POLY       32'hedb88320
`define PDR_CRC_INIT       32'hffffffff
`define PDR_SF_SYMBOLS     9'h106
`define PDR_USED_SC        7'h7f
`define PDR_MAX_WINDOWS    5'h10
`define PDR_BACKOFF_RST    8'h08
`define PDR_RND_RST        8'ha5
`endif

// ---- logic/pdr_discovery.sv ----
// Subscriber unit discovery response: window backoff, response build, allocation
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "pdr_defs.svh"
module pdr_discovery
    import pdr_pkg::*;
#(
    parameter logic [79:0] LDPC_MASK = 80'h8421_0842_1084_2108_4211
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire pdr_msg_t    msg,
    input  wire logic        sym_tick,
    input  wire logic        scan_excluded,
    output logic [11:0]      scan_sc,
    output pdr_sc_t          tx,
    output pdr_txkind_t      transmit_kind_select,
    output logic [7:0]       upstream_prefix_length,
    output logic [7:0]       upstream_rolloff_length,
    output logic             superframe_start,
    output logic             discovery_complete,
    output logic [14:0]      node_identifier,
    output logic [31:0]      accumulated_ranging_offset,
    output logic [15:0]      power_correction
);

    function automatic logic [31:0] crc32(input logic [47:0] d);
        logic [31:0] c;
        c = `PDR_CRC_INIT;
        for (int i = 0; i < 48; i++)
        begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ `PDR_CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction : crc32

    // Parity row j uses the mask rotated by j; stands in for the code's matrix
    function automatic logic [127:0] ldpc_enc(input logic [79:0] info);
        logic [47:0] par;
        logic [79:0] m;
        par = '0;
        m = LDPC_MASK;
        for (int j = 0; j < 48; j++)
        begin
            par[j] = ^(info & m);
            m = {m[78:0], m[79]};
        end
        return {par, info};
    endfunction : ldpc_enc

    function automatic logic [7:0] draw(input logic [7:0] r, input logic [7:0] b);
        logic [7:0] bb;
        bb = (b == 8'h00) ? 8'h01 : b;
        return (r % bb) + 8'h01;
    endfunction : draw

    // Allocation blocks count only with a broadcast destination
    function automatic logic alloc_hit(input pdr_msg_t m, input pdr_mb_kind_t k);
        return m.valid && m.bcast_dest && (m.kind == k);
    endfunction : alloc_hit

    pdr_state_t   state_ff;
    logic         ready_ff;
    logic [47:0]  station_ff;
    logic [31:0]  rdelay_ff;
    logic [7:0]   rnd_ff;
    logic [7:0]   bound_ff;
    logic [7:0]   backoff_ff;
    logic [4:0]   win_cnt_ff;
    logic [11:0]  start_ff;
    logic [31:0]  delay_cnt_ff;
    logic [127:0] cw_ff;
    logic [6:0]   prbs_ff;
    logic [6:0]   used_ff;
    logic         sym_ff;
    logic [8:0]   sf_cnt_ff;
    logic         addr_match_ff;
    logic         id_ok_ff;
    logic         wr_ctrl;
    logic         is_probe;
    logic         take_win;
    logic         win_room;
    logic         sending;
    logic         last_sc;
    logic [7:0]   nxt_backoff;

    assign wr_ctrl  = reg_wr && (reg_addr == `PDR_REG_CTRL);
    assign is_probe = msg.valid && ((msg.kind == MB_PROBE_BCAST) || (msg.kind == MB_PROBE_UCAST));
    assign win_room = (win_cnt_ff < `PDR_MAX_WINDOWS);
    // Unicast windows bypass the backoff count
    assign take_win = is_probe && win_room &&
                      ((msg.kind == MB_PROBE_UCAST) || (backoff_ff <= 8'h01));
    assign sending  = (state_ff == ST_SEND) && !scan_excluded;
    assign last_sc  = sending && (used_ff == `PDR_USED_SC);
    assign nxt_backoff = draw(rnd_ff, bound_ff);

    // Software registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ready_ff                <= 1'b0;
            station_ff              <= '0;
            rdelay_ff               <= '0;
            bound_ff                <= `PDR_BACKOFF_RST;
            upstream_prefix_length  <= '0;
            upstream_rolloff_length <= '0;
        end
        else if (ce && reg_wr)
        begin
            unique case (reg_addr)
                `PDR_REG_CTRL:    ready_ff <= reg_wdata[`PDR_CTRL_READY_BIT];
                `PDR_REG_ADDR_LO: station_ff[31:0] <= reg_wdata;
                `PDR_REG_ADDR_HI: station_ff[47:32] <= reg_wdata[15:0];
                `PDR_REG_RDELAY:  rdelay_ff <= reg_wdata;
                `PDR_REG_BACKOFF: bound_ff <= reg_wdata[15:8];
                `PDR_REG_LENS:
                begin
                    upstream_prefix_length  <= reg_wdata[7:0];
                    upstream_rolloff_length <= reg_wdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Read port, data valid only in the cycle after the strobe
    // Reads have no side effects, so status may be polled freely
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `PDR_REG_CTRL:    reg_rdata <= {31'h0, ready_ff};
                    `PDR_REG_ADDR_LO: reg_rdata <= station_ff[31:0];
                    `PDR_REG_ADDR_HI: reg_rdata <= {16'h0, station_ff[47:32]};
                    `PDR_REG_RDELAY:  reg_rdata <= rdelay_ff;
                    `PDR_REG_BACKOFF: reg_rdata <= {16'h0, bound_ff, rnd_ff};
                    `PDR_REG_LENS:
                        reg_rdata <= {16'h0, upstream_rolloff_length, upstream_prefix_length};
                    `PDR_REG_STATUS:
                        reg_rdata <= {node_identifier, win_cnt_ff, backoff_ff,
                                      state_ff, discovery_complete};
                    `PDR_REG_RANGING: reg_rdata <= accumulated_ranging_offset;
                    `PDR_REG_POWER:   reg_rdata <= {16'h0, power_correction};
                    default:          reg_rdata <= '0;
                endcase
            end
        end
    end

    // Backoff entropy; free running so units seeded alike still drift apart
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rnd_ff <= `PDR_RND_RST;
        else if (ce)
        begin
            if (reg_wr && (reg_addr == `PDR_REG_BACKOFF))
                rnd_ff <= reg_wdata[7:0];
            else
                rnd_ff <= {rnd_ff[6:0], rnd_ff[7] ^ rnd_ff[5] ^ rnd_ff[4] ^ rnd_ff[3]};
        end
    end

    // Superframe symbol counter and one-clock start strobe
    // Counts sym_tick only, so the period follows the downstream symbol clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sf_cnt_ff        <= '0;
            superframe_start <= 1'b0;
        end
        else if (ce)
        begin
            superframe_start <= 1'b0;
            if (sym_tick)
            begin
                if (sf_cnt_ff == `PDR_SF_SYMBOLS - 9'h001)
                begin
                    sf_cnt_ff        <= '0;
                    superframe_start <= 1'b1;
                end
                else
                    sf_cnt_ff <= sf_cnt_ff + 9'h001;
            end
        end
    end

    // Discovery control
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_ff <= ST_OFFLINE;
        else if (ce)
        begin
            // Dropping ready abandons a pending response
            if (!ready_ff)
                state_ff <= ST_OFFLINE;
            else if (discovery_complete)
                state_ff <= ST_DONE;
            else
            begin
                unique case (state_ff)
                    ST_OFFLINE:  state_ff <= ST_WAIT_WIN;
                    ST_WAIT_WIN: if (take_win) state_ff <= ST_ARMED;
                    ST_ARMED:
                        if (superframe_start)
                            state_ff <= (rdelay_ff == 32'h0) ? ST_SEND : ST_DELAY;
                    ST_DELAY:
                        if (delay_cnt_ff == 32'h1) state_ff <= ST_SEND;
                    ST_SEND:
                        if (last_sc && sym_ff) state_ff <= ST_WAIT_WIN;
                    ST_DONE:     state_ff <= ST_WAIT_WIN;
                    default:     state_ff <= ST_OFFLINE;
                endcase
            end
        end
    end

    // Window tracking and backoff count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            backoff_ff <= 8'h01;
            win_cnt_ff <= '0;
            start_ff   <= '0;
        end
        else if (ce)
        begin
            if (superframe_start)
                win_cnt_ff <= '0;
            else if (is_probe && win_room)
                win_cnt_ff <= win_cnt_ff + 5'h01;
            if ((state_ff == ST_OFFLINE) || (last_sc && sym_ff))
                backoff_ff <= nxt_backoff;
            else if ((state_ff == ST_WAIT_WIN) && take_win)
                start_ff <= msg.data[11:0];
            else if ((state_ff == ST_WAIT_WIN) && is_probe && (msg.kind == MB_PROBE_BCAST)
                     && win_room)
                backoff_ff <= backoff_ff - 8'h01;
        end
    end

    // Optional ranging delay before the response
    // Counts clk cycles; software converts from the ranging time unit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            delay_cnt_ff <= '0;
        else if (ce)
        begin
            if ((state_ff == ST_ARMED) && superframe_start)
                delay_cnt_ff <= rdelay_ff;
            else if (state_ff == ST_DELAY)
                delay_cnt_ff <= delay_cnt_ff - 32'h1;
        end
    end

    // Response builder: one subcarrier per enabled clock
    // Codeword is rebuilt on every idle clock, so address writes need no handshake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scan_sc <= '0;
            used_ff <= '0;
            sym_ff  <= 1'b0;
            prbs_ff <= `PDR_PRBS_SEED;
            cw_ff   <= '0;
        end
        else if (ce)
        begin
            if (state_ff != ST_SEND)
            begin
                scan_sc <= start_ff;
                used_ff <= '0;
                sym_ff  <= 1'b0;
                prbs_ff <= `PDR_PRBS_SEED;
                cw_ff   <= ldpc_enc({crc32(station_ff), station_ff});
            end
            else
            begin
                if (last_sc)
                begin
                    scan_sc <= start_ff;
                    used_ff <= '0;
                    sym_ff  <= 1'b1;
                end
                else
                begin
                    scan_sc <= scan_sc + 12'h001;
                    if (sending)
                        used_ff <= used_ff + 7'h01;
                end
                if (sending && !sym_ff)
                    prbs_ff <= {prbs_ff[5:0], prbs_ff[6] ^ prbs_ff[0]};
            end
        end
    end

    // Subcarrier output; each logical symbol is sent twice by the iFFT stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx                   <= '0;
            transmit_kind_select <= TXK_NORMAL;
        end
        else if (ce)
        begin
            tx.valid <= sending;
            tx.sym   <= sym_ff;
            tx.sc    <= scan_sc;
            // Preamble in logical symbol 0, codeword in logical symbol 1
            tx.neg   <= sym_ff ? cw_ff[used_ff] : prbs_ff[6];
            transmit_kind_select <= (state_ff == ST_SEND) ? TXK_DUP : TXK_NORMAL;
        end
    end

    // Identifier allocation and corrections
    // Matches are dropped once corrections land, so a stale match cannot repeat
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addr_match_ff              <= 1'b0;
            id_ok_ff                   <= 1'b0;
            node_identifier            <= '0;
            accumulated_ranging_offset <= '0;
            power_correction           <= '0;
            discovery_complete         <= 1'b0;
        end
        else if (ce)
        begin
            if (alloc_hit(msg, MB_ALLOC_ADDR))
            begin
                addr_match_ff <= (msg.data == station_ff);
                id_ok_ff      <= 1'b0;
            end
            if (alloc_hit(msg, MB_ALLOC_ID) && addr_match_ff)
            begin
                node_identifier <= msg.data[14:0];
                id_ok_ff        <= 1'b1;
            end
            // Set wins over a rejoin write in the same cycle
            if (alloc_hit(msg, MB_ALLOC_CORR) && id_ok_ff)
            begin
                accumulated_ranging_offset <= accumulated_ranging_offset
                                              + msg.data[31:0];
                power_correction   <= msg.data[47:32];
                discovery_complete <= 1'b1;
                addr_match_ff      <= 1'b0;
                id_ok_ff           <= 1'b0;
            end
            else if (wr_ctrl && reg_wdata[`PDR_CTRL_REJOIN_BIT])
                discovery_complete <= 1'b0;
        end
    end

endmodule : pdr_discovery

// ---- logic/pdr_pkg.sv ----
// Types shared by the discovery response block
package pdr_pkg;
    typedef enum logic [2:0] {
        MB_NONE        = 3'h0,
        MB_PROBE_BCAST = 3'h1,
        MB_PROBE_UCAST = 3'h2,
        MB_ALLOC_ADDR  = 3'h3,
        MB_ALLOC_ID    = 3'h4,
        MB_ALLOC_CORR  = 3'h5
    } pdr_mb_kind_t;
    typedef struct packed {
        logic         valid;
        pdr_mb_kind_t kind;
        logic         bcast_dest;
        logic [47:0]  data;
    } pdr_msg_t;
    typedef struct packed {
        logic        valid;
        logic        sym;
        logic [11:0] sc;
        logic        neg;
    } pdr_sc_t;
    typedef enum logic [2:0] {
        ST_OFFLINE  = 3'h0,
        ST_WAIT_WIN = 3'h1,
        ST_ARMED    = 3'h2,
        ST_DELAY    = 3'h3,
        ST_SEND     = 3'h4,
        ST_DONE     = 3'h5
    } pdr_state_t;
    typedef enum logic [1:0] {
        TXK_NORMAL = 2'h0,
        TXK_DUP    = 2'h1
    } pdr_txkind_t;
endpackage : pdr_pkg

// ---- tb/pdr_checker.sv ----
// Concurrent checks on the discovery response block ports
`timescale 1ns/1ps
module pdr_checker
    import pdr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire pdr_msg_t    msg,
    input wire logic        scan_excluded,
    input wire logic [11:0] scan_sc,
    input wire pdr_sc_t     tx,
    input wire pdr_txkind_t transmit_kind_select,
    input wire logic        superframe_start,
    input wire logic        discovery_complete,
    input wire logic [14:0] node_identifier,
    input wire logic [31:0] accumulated_ranging_offset,
    input wire logic [15:0] power_correction
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence id_taken_s;
        $changed(node_identifier);
    endsequence
    sequence corr_msg_s;
        ce && msg.valid && msg.kind == MB_ALLOC_CORR && msg.bcast_dest;
    endsequence
    sf_pulse_a: assert property (ce && superframe_start |=> !superframe_start)
        else $error("superframe strobe longer than one cycle");
    dup_kind_a: assert property (tx.valid |-> transmit_kind_select == TXK_DUP)
        else $error("subcarrier sent without duplication");
    excl_skip_a: assert property (ce && scan_excluded |=> !tx.valid)
        else $error("excluded subcarrier was used");
    sc_order_a: assert property (tx.valid |-> tx.sc == $past(scan_sc))
        else $error("subcarrier index differs from scan");
    id_load_a: assert property ($changed(node_identifier) |->
        $past(msg.valid && msg.kind == MB_ALLOC_ID && msg.bcast_dest)
        && node_identifier == $past(msg.data[14:0]))
        else $error("identifier changed without an allocation block");
    ranging_sum_a: assert property ($changed(accumulated_ranging_offset) |->
        accumulated_ranging_offset == $past(accumulated_ranging_offset) + $past(msg.data[31:0]))
        else $error("timing correction not accumulated");
    power_load_a: assert property ($changed(power_correction) |->
        power_correction == $past(msg.data[47:32]))
        else $error("power correction differs from block");
    done_set_a: assert property (id_taken_s ##[1:4] corr_msg_s |=> discovery_complete)
        else $error("discovery not complete after corrections");
    done_cause_a: assert property ($rose(discovery_complete) |->
        $past(msg.valid && msg.kind == MB_ALLOC_CORR))
        else $error("discovery complete without correction block");
endmodule : pdr_checker
bind pdr_discovery pdr_checker u_chk (
    .clk(clk), .rst(rst), .ce(ce), .msg(msg), .scan_excluded(scan_excluded),
    .scan_sc(scan_sc), .tx(tx), .transmit_kind_select(transmit_kind_select),
    .superframe_start(superframe_start), .discovery_complete(discovery_complete),
    .node_identifier(node_identifier), .power_correction(power_correction),
    .accumulated_ranging_offset(accumulated_ranging_offset)
);

// ---- tb/pdr_headend_model.sv ----
// Headend line terminal model: message blocks, symbol ticks, excluded subcarriers
`timescale 1ns/1ps
module pdr_headend_model
    import pdr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] scan_sc,
    output pdr_msg_t         msg,
    output logic             sym_tick,
    output logic             scan_excluded
);
    logic tick_ff;
    initial
    begin
        msg = '0;
    end
    // A symbol every second clock keeps the 262-symbol superframe short
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tick_ff <= 1'b0;
        else
            tick_ff <= ~tick_ff;
    end
    assign sym_tick = tick_ff;
    // One subcarrier in eight is excluded so the span must skip inside itself
    assign scan_excluded = (scan_sc[2:0] == 3'h5);
    // Probe and allocation blocks, at most sixteen windows a period
    task automatic send_block(input pdr_mb_kind_t k, input logic b, input logic [47:0] d);
        @(posedge clk);
        msg <= '{valid: 1'b1, kind: k, bcast_dest: b, data: d};
        @(posedge clk);
        // Released data and destination lines carry the inverse; kind keeps a stale copy
        msg <= '{valid: 1'b0, kind: k, bcast_dest: ~b, data: ~d};
    endtask : send_block
endmodule : pdr_headend_model

// ---- tb/tb.sv ----
// Self-checking bench for the discovery response block
`timescale 1ns/1ps
`include "pdr_defs.svh"
module tb;
    import pdr_pkg::*;
    localparam logic [47:0] STA = 48'h0a1b_2c3d_4e5f;
    localparam logic [11:0] WIN = 12'h100;
    localparam logic [11:0] WIN2 = 12'h208;
    logic        clk, rst, ce, reg_wr, reg_rd, sym_tick, scan_excluded, sf_start, dc;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rng_off;
    logic [11:0] scan_sc;
    logic [14:0] node_id;
    logic [15:0] pwr;
    logic [7:0]  pre_len, roll_len;
    pdr_msg_t    msg;
    pdr_sc_t     tx;
    pdr_txkind_t txk;
    int          errors, n_checks;
    logic        q_sym[$], q_neg[$];
    logic [11:0] q_sc[$];

    pdr_discovery DUT (
        .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg(msg),
        .sym_tick(sym_tick), .scan_excluded(scan_excluded), .scan_sc(scan_sc), .tx(tx),
        .transmit_kind_select(txk), .upstream_prefix_length(pre_len),
        .upstream_rolloff_length(roll_len),
        .superframe_start(sf_start), .discovery_complete(dc), .node_identifier(node_id),
        .accumulated_ranging_offset(rng_off), .power_correction(pwr)
    );
    pdr_headend_model hem (
        .clk(clk), .rst(rst), .scan_sc(scan_sc), .msg(msg), .sym_tick(sym_tick),
        .scan_excluded(scan_excluded)
    );

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        if (tx.valid === 1'b1)
        begin
            q_sym.push_back(tx.sym);
            q_neg.push_back(tx.neg);
            q_sc.push_back(tx.sc);
        end
    end

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic wait_sf(output int n);
        for (n = 1; n < 1200; n++)
        begin
            @(posedge clk);
            if (sf_start === 1'b1)
                return;
        end
        errors++;
        print_verdict();
    endtask : wait_sf

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        logic [31:0] d;
        logic [31:0] crc;
        logic [7:0]  b;
        logic [6:0]  s;
        logic [11:0] sc;
        int          n;
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_read(8'h40, d);
        check(48'(d), 48'h0);
        reg_read(`PDR_REG_RDELAY, d);
        check(48'(d), 48'h0);
        wait_sf(n);
        wait_sf(n);
        check(48'(n), 48'h20c);
        reg_write(`PDR_REG_ADDR_LO, STA[31:0]);
        reg_write(`PDR_REG_ADDR_HI, {16'h0, STA[47:32]});
        reg_write(`PDR_REG_BACKOFF, 32'h0000_033c);
        hem.send_block(MB_PROBE_UCAST, 1'b1, 48'(WIN));
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[3:1]), 48'(ST_OFFLINE));
        reg_write(`PDR_REG_CTRL, 32'h1);
        reg_read(`PDR_REG_STATUS, d);
        b = d[11:4];
        check(48'(d[3:1]), 48'(ST_WAIT_WIN));
        check(48'(b >= 8'h1 && b <= 8'h3), 48'h1);
        // Start of a superframe leaves room to see the armed state
        wait_sf(n);
        for (int i = 1; i < b; i++)
            hem.send_block(MB_PROBE_BCAST, 1'b1, 48'h200 + 48'(i));
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[3:1]), 48'(ST_WAIT_WIN));
        hem.send_block(MB_PROBE_BCAST, 1'b1, 48'(WIN));
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[3:1]), 48'(ST_ARMED));
        for (n = 0; n < 2000 && q_sc.size() < 256; n++)
            @(posedge clk);
        if (q_sc.size() < 256)
        begin
            errors++;
            print_verdict();
        end
        crc = `PDR_CRC_INIT;
        for (int i = 0; i < 48; i++)
            crc = (crc[0] ^ STA[i]) ? (crc >> 1) ^ `PDR_CRC_POLY : crc >> 1;
        crc = ~crc;
        s = `PDR_PRBS_SEED;
        for (int k = 0; k < 256; k++)
        begin
            if (k == 0 || k == 128)
                sc = WIN;
            while (sc[2:0] == 3'h5)
                sc++;
            check(48'(q_sc[k]), 48'(sc));
            check(48'(q_sym[k]), 48'(k >= 128));
            if (k < 128)
            begin
                check(48'(q_neg[k]), 48'(s[6]));
                s = {s[5:0], s[6] ^ s[0]};
            end
            else if (k < 176)
                check(48'(q_neg[k]), 48'(STA[k - 128]));
            else if (k < 208)
                check(48'(q_neg[k]), 48'(crc[k - 176]));
            sc++;
        end
        hem.send_block(MB_ALLOC_ADDR, 1'b1, ~STA);
        hem.send_block(MB_ALLOC_ID, 1'b1, 48'h1234);
        hem.send_block(MB_ALLOC_ADDR, 1'b1, STA);
        hem.send_block(MB_ALLOC_ID, 1'b0, 48'h1234);
        repeat (2) @(posedge clk);
        check(48'(node_id), 48'h0);
        hem.send_block(MB_ALLOC_ADDR, 1'b1, STA);
        hem.send_block(MB_ALLOC_ID, 1'b1, 48'h1234);
        hem.send_block(MB_ALLOC_CORR, 1'b1, 48'h00aa_0000_0010);
        repeat (2) @(posedge clk);
        check(48'(node_id), 48'h1234);
        check(48'(pwr), 48'haa);
        check(48'(dc), 48'h1);
        hem.send_block(MB_ALLOC_ADDR, 1'b1, STA);
        hem.send_block(MB_ALLOC_ID, 1'b1, 48'h1234);
        hem.send_block(MB_ALLOC_CORR, 1'b1, 48'h0055_ffff_fff8);
        reg_read(`PDR_REG_RANGING, d);
        check(48'(d), 48'h8);
        check(48'(rng_off), 48'h8);
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[0]), 48'h1);
        check(48'(q_sc.size()), 48'h100);
        // Strobes while the clock enable is low must be ignored
        @(posedge clk);
        ce <= 1'b0;
        reg_write(`PDR_REG_CTRL, 32'h3);
        ce <= 1'b1;
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[0]), 48'h1);
        reg_write(`PDR_REG_LENS, 32'h0000_2a15);
        reg_write(`PDR_REG_CTRL, 32'h3);
        reg_write(`PDR_REG_RDELAY, 32'h10);
        check(48'(pre_len), 48'h15);
        check(48'(roll_len), 48'h2a);
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[0]), 48'h0);
        check(48'(d[3:1]), 48'(ST_WAIT_WIN));
        // Unicast window right after a superframe start, so ARMED is seen
        wait_sf(n);
        hem.send_block(MB_PROBE_UCAST, 1'b1, 48'(WIN2));
        reg_read(`PDR_REG_STATUS, d);
        check(48'(d[3:1]), 48'(ST_ARMED));
        wait_sf(n);
        for (n = 1; n < 100 && tx.valid !== 1'b1; n++)
            @(posedge clk);
        // Sixteen delay clocks plus the state, scan and output registers
        check(48'(n), 48'h13);
        @(posedge clk);
        check(48'(q_sc[256]), 48'(WIN2));
        print_verdict();
    end
endmodule : tb
